//--- src/mbd_top.sv
// What this block does
// - function 08 queries carry a 16-bit subfunction selecting the action
// - accept subfunctions 00-04 and 10-20; 00 echoes, 01 restarts
// - subfunction 03 sets ascii delimiter; ignored in rtu framing
// - subfunction 04 enters listen-only; activity indicator blinks then
// - subfunction 10 zeroes all counters and the fault status word
// - subfunctions 11-15 and 18 return the six kept counts
// - subfunction 20 zeroes overrun counter and overrun flag
// - subfunctions 16, 17, 19 always answer a zero word
// - subfunction 02 returns fault word: two bytes rtu, four hex chars ascii
// - fault word first eight flags: fatal through scan diagnostic
// - fault word last eight flags: rom diagnostic through os ram parity
// - compatibility option selects standard or legacy exception codes
// - standard: 01 function, 02 address, 03 value
// - standard: 04 device failure, 08 memory parity
// - legacy: 00 function, 01 data type, 02 address
// - legacy: 0B failure, 10 count range, 15 write protect
// - legacy: 19 start plus count out of range, 1D zero count
`timescale 1ns/10ps
`include "mbd_map.svh"
module mbd_top #(
  parameter int unsigned BLINK_HALF_CYC = `MBD_BLINK_MS * `MBD_CLK_KHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link configuration
  input wire logic ascii_mode,
  input wire logic legacy_nim_compat,
  // query in
  input wire logic qry_valid,
  output logic qry_ready,
  input wire mbd_pkg::mbd_query_t qry,
  // reply out
  output logic rsp_valid,
  input wire logic rsp_ready,
  output mbd_pkg::mbd_resp_t rsp,
  // event pulses and fault sources
  input wire mbd_pkg::mbd_evt_t evt,
  input wire mbd_pkg::mbd_fault_t fault_set,
  // status and side effects
  output mbd_pkg::mbd_fault_t plc_fault_status_word,
  output logic overrun_flag,
  output logic listen_only,
  output logic restart_pulse,
  output logic [7:0] ascii_delim,
  input wire logic activity,
  output logic activity_led
);
  ////////////////////////////////////////////////////////////////////////
  mbd_pkg::mbd_state_t state;
  mbd_pkg::mbd_state_t next_state;
  mbd_pkg::mbd_query_t q;
  logic [15:0] cnt [`MBD_CNT_N];
  logic [`MBD_CNT_N-1:0] evt_v;
  logic [`MBD_CNT_N-1:0] cnt_clr;

  // map an error cause to the code of the selected set
  function automatic logic [7:0] exc_code(input logic legacy,
                                          input mbd_pkg::mbd_err_t e);
    logic [7:0] c;
    c = legacy ? `MBD_XL_FAIL : `MBD_XS_FAIL;
    if (!legacy) begin
      case (e)
        mbd_pkg::ERR_ADDR: c = `MBD_XS_ADDR;
        mbd_pkg::ERR_VALUE: c = `MBD_XS_VALUE;
        mbd_pkg::ERR_PARITY: c = `MBD_XS_PARITY;
        mbd_pkg::ERR_FAIL: c = `MBD_XS_FAIL;
        default: c = `MBD_XS_FUNC;
      endcase
    end else begin
      case (e)
        mbd_pkg::ERR_TYPE: c = `MBD_XL_TYPE;
        mbd_pkg::ERR_ADDR: c = `MBD_XL_ADDR;
        mbd_pkg::ERR_COUNT: c = `MBD_XL_COUNT;
        mbd_pkg::ERR_WPROT: c = `MBD_XL_WPROT;
        mbd_pkg::ERR_RANGE: c = `MBD_XL_RANGE;
        mbd_pkg::ERR_ZERO: c = `MBD_XL_ZERO;
        mbd_pkg::ERR_FAIL: c = `MBD_XL_FAIL;
        default: c = `MBD_XL_FUNC;
      endcase
    end
    return c;
  endfunction : exc_code

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < `MBD_NIB_TEN) ? `MBD_ASC_DIGIT + 8'(n)
                              : `MBD_ASC_ALPHA + 8'(n);
  endfunction : hex_char

  ////////////////////////////////////////////////////////////////////////
  // decode of the latched query
  wire logic in_exec = (state == mbd_pkg::ST_EXEC);
  wire logic is_diag = (q.func == `MBD_FC_DIAG);
  wire logic sf_ok = (q.subfn <= `MBD_SF_LISTEN) ||
                     ((q.subfn >= `MBD_SF_CLR_ALL) &&
                      (q.subfn <= `MBD_SF_CLR_OVR));
  wire logic no_err = (q.err == mbd_pkg::ERR_NONE);
  wire logic do_diag = in_exec && is_diag && sf_ok && no_err;
  wire logic do_exc = in_exec && !(is_diag && sf_ok && no_err);
  wire logic clr_all = do_diag && (q.subfn == `MBD_SF_CLR_ALL);
  wire logic clr_ovr = do_diag && (q.subfn == `MBD_SF_CLR_OVR);
  wire logic do_restart = do_diag && (q.subfn == `MBD_SF_RESTART);
  wire logic do_listen = do_diag && (q.subfn == `MBD_SF_LISTEN);
  // rtu framing has no delimiter, so the write is dropped there
  wire logic do_delim = do_diag && (q.subfn == `MBD_SF_DELIM) &&
                        ascii_mode;
  // in listen-only only a restart is answered; 04 itself never is
  wire logic silent = !do_restart && (listen_only || do_listen);
  wire logic [15:0] fault_w = plc_fault_status_word;

  // reply word for each subfunction
  logic [15:0] diag_word;
  always_comb begin
    case (q.subfn)
      `MBD_SF_FAULT: diag_word = fault_w;
      `MBD_SF_BUS_MSG: diag_word = cnt[0];
      `MBD_SF_COMM_ERR: diag_word = cnt[1];
      `MBD_SF_EXC_ERR: diag_word = cnt[2];
      `MBD_SF_SLV_MSG: diag_word = cnt[3];
      `MBD_SF_NO_RSP: diag_word = cnt[4];
      `MBD_SF_OVR_CNT: diag_word = cnt[`MBD_CNT_OVR];
      `MBD_SF_NAK, `MBD_SF_BUSY,
      `MBD_SF_IOP_OVR: diag_word = `MBD_ZERO_WORD;
      default: diag_word = q.data; // echo for 00, 01, 03, 04, 10, 20
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // control sequence: take query, act one cycle, hold reply
  assign qry_ready = (state == mbd_pkg::ST_IDLE);
  assign rsp_valid = (state == mbd_pkg::ST_REPLY);
  always_comb begin
    case (state)
      mbd_pkg::ST_IDLE:
        next_state = qry_valid ? mbd_pkg::ST_EXEC : mbd_pkg::ST_IDLE;
      mbd_pkg::ST_EXEC:
        next_state = silent ? mbd_pkg::ST_IDLE : mbd_pkg::ST_REPLY;
      mbd_pkg::ST_REPLY:
        next_state = rsp_ready ? mbd_pkg::ST_IDLE : mbd_pkg::ST_REPLY;
      default: next_state = mbd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= mbd_pkg::ST_IDLE;
      q <= '0;
    end else begin
      state <= next_state;
      if (qry_valid && qry_ready) begin
        q <= qry;
      end
    end
  end

  // reply register, built in the exec cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= '0;
    end else if (in_exec) begin
      rsp.exc <= do_exc;
      rsp.func <= do_exc ? (q.func | `MBD_FC_EXC_BIT) : q.func;
      rsp.code <= do_exc ? exc_code(legacy_nim_compat, q.err)
                         : 8'h00;
      rsp.subfn <= q.subfn;
      rsp.word <= diag_word;
      rsp.ascii <= ascii_mode;
      for (int i = 0; i < 4; i++) begin
        rsp.ascii_word[i*8 +: 8] <= hex_char(diag_word[i*4 +: 4]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode flags and delimiter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      listen_only <= 1'b0;
      restart_pulse <= 1'b0;
      ascii_delim <= `MBD_DELIM_RST;
    end else begin
      restart_pulse <= do_restart;
      if (do_listen) begin
        listen_only <= 1'b1;
      end else if (do_restart) begin
        listen_only <= 1'b0;
      end
      if (do_delim) begin
        ascii_delim <= q.data[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counters; our own exceptions also count as exception errors
  assign evt_v = evt | {3'b000, do_exc, 2'b00};
  genvar g;
  generate
    for (g = 0; g < `MBD_CNT_N; g++) begin : g_cnt
      assign cnt_clr[g] = clr_all || (clr_ovr && g == `MBD_CNT_OVR);
      // an event in the clearing cycle is kept: set beats clear
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt[g] <= `MBD_ZERO_WORD;
        end else if (evt_v[g]) begin
          cnt[g] <= cnt_clr[g] ? 16'h0001 : cnt[g] + 16'h0001;
        end else if (cnt_clr[g]) begin
          cnt[g] <= `MBD_ZERO_WORD;
        end
      end
    end
  endgenerate

  // sticky flags; set wins over clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      plc_fault_status_word <= '0;
      overrun_flag <= 1'b0;
    end else begin
      plc_fault_status_word <= fault_set |
        (clr_all ? '0 : plc_fault_status_word);
      overrun_flag <= evt.overrun ||
        (overrun_flag && !(clr_ovr || clr_all));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // activity indicator blinks in listen-only
  mbd_blink #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .blink_en(listen_only),
    .steady(activity),
    .led(activity_led)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_take(logic [15:0] sf);
    qry_valid && qry_ready && qry.func == `MBD_FC_DIAG &&
    qry.subfn == sf && qry.err == mbd_pkg::ERR_NONE;
  endsequence
  sequence s_exec;
    in_exec ##1 1'b1;
  endsequence

  property p_diag_func;
    @(posedge core_clk) disable iff (!rst_n)
    rsp_valid && !rsp.exc |-> rsp.func == `MBD_FC_DIAG;
  endproperty
  a_diag_func: assert property (p_diag_func)
    else $error("normal reply without diagnostics function");

  property p_echo;
    @(posedge core_clk) disable iff (!rst_n)
    s_take(`MBD_SF_ECHO) ##0 !listen_only ##1 s_exec |->
      rsp_valid && rsp.word == $past(qry.data, 2);
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo reply data mismatch");

  property p_rtu_delim;
    @(posedge core_clk) disable iff (!rst_n)
    in_exec && !ascii_mode |=> $stable(ascii_delim);
  endproperty
  a_rtu_delim: assert property (p_rtu_delim)
    else $error("delimiter changed in rtu framing");

  property p_listen;
    @(posedge core_clk) disable iff (!rst_n)
    s_take(`MBD_SF_LISTEN) |-> ##2 listen_only && !rsp_valid;
  endproperty
  a_listen: assert property (p_listen)
    else $error("listen-only not entered or reply sent");

  property p_clear_all;
    @(posedge core_clk) disable iff (!rst_n)
    clr_all && evt_v == '0 && fault_set == '0 |=>
      cnt[0] == `MBD_ZERO_WORD && cnt[3] == `MBD_ZERO_WORD &&
      plc_fault_status_word == '0;
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("counters or fault word not cleared");

  property p_clr_ovr;
    @(posedge core_clk) disable iff (!rst_n)
    clr_ovr && !evt.overrun |=>
      cnt[`MBD_CNT_OVR] == `MBD_ZERO_WORD && !overrun_flag;
  endproperty
  a_clr_ovr: assert property (p_clr_ovr)
    else $error("overrun counter or flag not cleared");

  property p_zero_counts;
    @(posedge core_clk) disable iff (!rst_n)
    rsp_valid && !rsp.exc && (rsp.subfn == `MBD_SF_NAK ||
      rsp.subfn == `MBD_SF_BUSY || rsp.subfn == `MBD_SF_IOP_OVR) |->
      rsp.word == `MBD_ZERO_WORD;
  endproperty
  a_zero_counts: assert property (p_zero_counts)
    else $error("unkept count answered non-zero");

  property p_exc_func;
    @(posedge core_clk) disable iff (!rst_n)
    do_exc |=> rsp.exc && rsp.func == ($past(q.func) | `MBD_FC_EXC_BIT);
  endproperty
  a_exc_func: assert property (p_exc_func)
    else $error("exception reply function byte wrong");

  property p_std_addr;
    @(posedge core_clk) disable iff (!rst_n)
    do_exc && !legacy_nim_compat && q.err == mbd_pkg::ERR_ADDR |=>
      rsp.code == `MBD_XS_ADDR;
  endproperty
  a_std_addr: assert property (p_std_addr)
    else $error("standard address exception code wrong");

  property p_leg_zero;
    @(posedge core_clk) disable iff (!rst_n)
    do_exc && legacy_nim_compat && q.err == mbd_pkg::ERR_ZERO |=>
      rsp.code == `MBD_XL_ZERO;
  endproperty
  a_leg_zero: assert property (p_leg_zero)
    else $error("legacy zero-count exception code wrong");
endmodule : mbd_top

//--- src/mbd_map.svh
`ifndef MBD_MAP_SVH
`define MBD_MAP_SVH
// function codes
`define MBD_FC_DIAG 8'h08
`define MBD_FC_EXC_BIT 8'h80
// diagnostic subfunctions, printed decimal numbers
`define MBD_SF_ECHO 16'h0000
`define MBD_SF_RESTART 16'h0001
`define MBD_SF_FAULT 16'h0002
`define MBD_SF_DELIM 16'h0003
`define MBD_SF_LISTEN 16'h0004
`define MBD_SF_CLR_ALL 16'h000A
`define MBD_SF_BUS_MSG 16'h000B
`define MBD_SF_COMM_ERR 16'h000C
`define MBD_SF_EXC_ERR 16'h000D
`define MBD_SF_SLV_MSG 16'h000E
`define MBD_SF_NO_RSP 16'h000F
`define MBD_SF_NAK 16'h0010
`define MBD_SF_BUSY 16'h0011
`define MBD_SF_OVR_CNT 16'h0012
`define MBD_SF_IOP_OVR 16'h0013
`define MBD_SF_CLR_OVR 16'h0014
// standard exception codes
`define MBD_XS_FUNC 8'h01
`define MBD_XS_ADDR 8'h02
`define MBD_XS_VALUE 8'h03
`define MBD_XS_FAIL 8'h04
`define MBD_XS_PARITY 8'h08
// legacy-compatible exception codes
`define MBD_XL_FUNC 8'h00
`define MBD_XL_TYPE 8'h01
`define MBD_XL_ADDR 8'h02
`define MBD_XL_FAIL 8'h0B
`define MBD_XL_COUNT 8'h10
`define MBD_XL_WPROT 8'h15
`define MBD_XL_RANGE 8'h19
`define MBD_XL_ZERO 8'h1D
// counter indices and reset values
`define MBD_CNT_N 6
`define MBD_CNT_OVR 5
`define MBD_ZERO_WORD 16'h0000
`define MBD_DELIM_RST 8'h0A
// ascii hex conversion
`define MBD_ASC_DIGIT 8'h30
`define MBD_ASC_ALPHA 8'h37
`define MBD_NIB_TEN 4'hA
// blink timing
`define MBD_BLINK_MS 250
`define MBD_CLK_KHZ 40000
`endif

//--- src/mbd_pkg.sv
package mbd_pkg;
  // error cause reported alongside a query
  typedef enum logic [3:0] {
    ERR_NONE, ERR_FUNC, ERR_ADDR, ERR_VALUE, ERR_FAIL, ERR_PARITY,
    ERR_TYPE, ERR_COUNT, ERR_WPROT, ERR_RANGE, ERR_ZERO
  } mbd_err_t;
  // fault status word, first flag in the most significant bit
  typedef struct packed {
    logic fatal;
    logic other_hw;
    logic card_dl;
    logic board_fail;
    logic power_loss;
    logic scan_ovr;
    logic io_fatal;
    logic scan_diag;
    logic rom_diag;
    logic ram_diag;
    logic bad_opcode;
    logic dyn_mem_diag;
    logic watchdog;
    logic os_fatal;
    logic prog_ram_par;
    logic os_ram_par;
  } mbd_fault_t;
  typedef struct packed {
    logic [7:0] func;
    logic [15:0] subfn;
    logic [15:0] data;
    mbd_err_t err;
  } mbd_query_t;
  typedef struct packed {
    logic exc;
    logic [7:0] func;
    logic [7:0] code;
    logic [15:0] subfn;
    logic [15:0] word;
    logic ascii;
    logic [31:0] ascii_word;
  } mbd_resp_t;
  // order matches counter index
  typedef struct packed {
    logic overrun;
    logic no_resp;
    logic slave_msg;
    logic exc_err;
    logic comm_err;
    logic bus_msg;
  } mbd_evt_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_REPLY = 3'b100
  } mbd_state_t;
endpackage : mbd_pkg

//--- src/mbd_blink.sv
`timescale 1ns/10ps
`include "mbd_map.svh"
module mbd_blink #(
  parameter int unsigned HALF_CYC = `MBD_BLINK_MS * `MBD_CLK_KHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic blink_en,
  input wire logic steady,
  // indicator
  output logic led
);
  logic [23:0] cnt;
  logic phase;
  wire logic cnt_end = (cnt == 24'(HALF_CYC - 1));
  // half-period divider, restarts whenever blinking is off
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 24'h000000;
      phase <= 1'b0;
    end else if (!blink_en || cnt_end) begin
      cnt <= 24'h000000;
      phase <= blink_en ? ~phase : 1'b1;
    end else begin
      cnt <= cnt + 24'h000001;
    end
  end
  // steady follows normal activity outside listen-only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      led <= 1'b0;
    end else begin
      led <= blink_en ? phase : steady;
    end
  end
endmodule : mbd_blink

//--- tb/mbd_master.sv
`timescale 1ns/10ps
module mbd_master (
  // clock
  input wire logic core_clk,
  // query side
  output logic qry_valid,
  input wire logic qry_ready,
  output mbd_pkg::mbd_query_t qry,
  // reply side
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire mbd_pkg::mbd_resp_t rsp
);
  initial begin
    qry_valid = 1'b0;
    qry = '0;
    rsp_ready = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one query, then a bounded wait for the reply; stall delays acceptance
  task automatic xfer(input mbd_pkg::mbd_query_t q, input int stall,
                      output mbd_pkg::mbd_resp_t r, output bit got);
    int n;
    got = 1'b0;
    r = '0;
    qry = q; // subfunction field always travels with the function
    qry_valid = 1'b1;
    for (n = 0; n < 8 && qry_ready !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
    qry_valid = 1'b0;
    qry = ~q; // released lines never keep the old value
    for (n = 0; n < 6 && rsp_valid !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (rsp_valid === 1'b1) begin
      repeat (stall) begin
        @(posedge core_clk);
        #1;
      end
      rsp_ready = 1'b1;
      r = rsp;
      got = 1'b1;
      @(posedge core_clk);
      #1;
      rsp_ready = 1'b0;
    end
  endtask : xfer
endmodule : mbd_master

//--- tb/tb_top.sv
`timescale 1ns/10ps
`include "mbd_map.svh"
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ascii_mode = 1'b0;
  logic legacy_nim_compat = 1'b0;
  logic activity = 1'b0;
  logic qry_valid, qry_ready, rsp_valid, rsp_ready;
  logic overrun_flag, listen_only, restart_pulse, activity_led;
  logic [7:0] ascii_delim;
  mbd_pkg::mbd_query_t qry;
  mbd_pkg::mbd_resp_t rsp, r;
  mbd_pkg::mbd_evt_t evt = '0;
  mbd_pkg::mbd_fault_t fault_set = '0;
  mbd_pkg::mbd_fault_t fsw;
  int n_fail = 0;
  int checks_done = 0;
  int n_restart = 0;
  bit got;
  // 25 ns period
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (restart_pulse === 1'b1) n_restart++;
  mbd_top #(.BLINK_HALF_CYC(4)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .ascii_mode(ascii_mode),
    .legacy_nim_compat(legacy_nim_compat), .qry_valid(qry_valid),
    .qry_ready(qry_ready), .qry(qry), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp(rsp), .evt(evt), .fault_set(fault_set),
    .plc_fault_status_word(fsw), .overrun_flag(overrun_flag),
    .listen_only(listen_only), .restart_pulse(restart_pulse),
    .ascii_delim(ascii_delim), .activity(activity),
    .activity_led(activity_led));
  mbd_master i_master (
    .core_clk(core_clk), .qry_valid(qry_valid), .qry_ready(qry_ready),
    .qry(qry), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp));
  //////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [63:0] g, input logic [63:0] e,
                     input string what);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, g, e);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic ask(input logic [7:0] fc, input logic [15:0] sf,
                     input logic [15:0] dat, input mbd_pkg::mbd_err_t e,
                     input int stall);
    mbd_pkg::mbd_query_t q;
    q = '{func: fc, subfn: sf, data: dat, err: e};
    i_master.xfer(q, stall, r, got);
  endtask : ask
  task automatic diag(input logic [15:0] sf, input logic [15:0] dat);
    ask(8'h08, sf, dat, mbd_pkg::ERR_NONE, 1);
  endtask : diag
  // one-cycle event and fault pulses
  task automatic pulse(input mbd_pkg::mbd_evt_t ev,
                       input mbd_pkg::mbd_fault_t fs);
    @(posedge core_clk);
    #1;
    evt = ev;
    fault_set = fs;
    @(posedge core_clk);
    #1;
    evt = '0;
    fault_set = '0;
  endtask : pulse
  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    chk({qry_ready, rsp_valid, overrun_flag, listen_only}, 4'h8,
        "rst");
    chk(fsw, 16'h0000, "rst fault word");
    chk(ascii_delim, 8'h0A, "rst delim");
  endtask : t_reset
  // back to back, first reply stalled one cycle, second three
  task automatic t_echo();
    diag(`MBD_SF_ECHO, 16'hA55A);
    chk({got, r.exc, r.subfn, r.word}, 34'h20000A55A, "echo");
    ask(8'h08, `MBD_SF_RESTART, 16'h1234, mbd_pkg::ERR_NONE, 3);
    chk({got, r.exc, r.word}, 18'h21234, "restart reply");
    chk(n_restart, 1, "restart pulse");
  endtask : t_echo
  task automatic t_counts();
    logic [15:0] sfs [6];
    mbd_pkg::mbd_fault_t fs;
    sfs = '{16'h000B, 16'h000C, 16'h000D, 16'h000E, 16'h000F, 16'h0012};
    fs = '0;
    fs.fatal = 1'b1;
    pulse(6'h3F, fs);
    diag(`MBD_SF_CLR_ALL, 16'h0000);
    chk(fsw, 16'h0000, "clear fault word");
    for (int i = 0; i < 6; i++) repeat (i + 1) pulse(6'(1 << i), '0);
    for (int i = 0; i < 6; i++) begin
      diag(sfs[i], 16'h0000);
      chk({got, r.exc, r.word}, {2'b10, 16'(i + 1)}, "count");
    end
    chk(overrun_flag, 1'b1, "overrun flag set");
    // a missing reply must not pass as a zero word
    diag(16'h0010, 16'h0000);
    chk({got, r.exc, r.word}, 18'h20000, "nak");
    diag(16'h0011, 16'h0000);
    chk({got, r.exc, r.word}, 18'h20000, "busy");
    diag(16'h0013, 16'h0000);
    chk({got, r.exc, r.word}, 18'h20000, "io_processor overrun");
    diag(`MBD_SF_CLR_OVR, 16'h0000);
    chk(overrun_flag, 1'b0, "overrun flag clear");
    diag(16'h0012, 16'h0000);
    chk({got, r.word}, 17'h10000, "overrun count clear");
    diag(16'h000B, 16'h0000);
    chk({got, r.word}, 17'h10001, "bus count kept");
  endtask : t_counts
  task automatic t_fault();
    mbd_pkg::mbd_fault_t fs;
    fs = '0;
    fs.fatal = 1'b1;
    pulse('0, fs);
    diag(`MBD_SF_FAULT, 16'h0000);
    chk({r.ascii, r.word, fsw}, 33'h080008000, "fault rtu");
    fs = '0;
    fs.scan_diag = 1'b1;
    fs.rom_diag = 1'b1;
    fs.os_ram_par = 1'b1;
    pulse('0, fs);
    ascii_mode = 1'b1;
    diag(`MBD_SF_FAULT, 16'h0000);
    chk({r.ascii, r.word}, 17'h18181, "fault ascii");
    chk(r.ascii_word, 32'h38313831, "fault hex chars");
    ascii_mode = 1'b0;
  endtask : t_fault
  task automatic t_delim();
    diag(`MBD_SF_DELIM, 16'h3B00);
    chk(ascii_delim, 8'h0A, "delim rtu");
    ascii_mode = 1'b1;
    diag(`MBD_SF_DELIM, 16'h3B00);
    chk(ascii_delim, 8'h3B, "delim ascii");
    ascii_mode = 1'b0;
  endtask : t_delim
  // every error cause under both code sets
  task automatic t_exc();
    logic [7:0] cs [10];
    logic [7:0] cl [10];
    cs = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h01, 8'h01, 8'h01, 8'h01,
           8'h01};
    cl = '{8'h00, 8'h02, 8'h00, 8'h0B, 8'h00, 8'h01, 8'h10, 8'h15, 8'h19,
           8'h1D};
    // start from zero so the own exceptions can be counted
    diag(`MBD_SF_CLR_ALL, 16'h0000);
    for (int m = 0; m < 2; m++) begin
      legacy_nim_compat = m[0];
      for (int i = 0; i < 10; i++) begin
        ask(8'h03, 16'h0000, 16'h0000, mbd_pkg::mbd_err_t'(i + 1), 0);
        chk({r.exc, r.func, r.code}, {9'h183, m ? cl[i] : cs[i]},
            "exception");
      end
      ask(8'h2B, 16'h0000, 16'h0000, mbd_pkg::ERR_NONE, 0);
      chk({r.exc, r.func, r.code}, {9'h1AB, m ? 8'h00 : 8'h01},
          "bad function");
      diag(16'h0005, 16'h0000);
      chk({got, r.exc}, 2'h3, "bad subfunction");
    end
    legacy_nim_compat = 1'b0;
    // twelve exceptions per code set
    diag(`MBD_SF_EXC_ERR, 16'h0000);
    chk({got, r.exc, r.word}, 18'h20018, "exception count");
  endtask : t_exc
  task automatic t_listen();
    int tog;
    logic prev;
    activity = 1'b1;
    diag(`MBD_SF_LISTEN, 16'h0000);
    chk({got, listen_only}, 2'h1, "listen silent");
    tog = 0;
    prev = activity_led;
    // count indicator changes from one settled sample to the next
    repeat (24) begin
      @(posedge core_clk);
      #1;
      if (activity_led !== prev) tog++;
      prev = activity_led;
    end
    chk(tog >= 4 && tog <= 7, 1'b1, "blink");
    diag(`MBD_SF_ECHO, 16'h0001);
    chk(got, 1'b0, "echo silent");
    diag(`MBD_SF_RESTART, 16'h0000);
    chk({got, listen_only}, 2'h2, "listen exit");
    repeat (3) @(posedge core_clk);
    #1;
    chk(activity_led, 1'b1, "led follows");
    activity = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(activity_led, 1'b0, "led follows");
  endtask : t_listen
  //////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    t_reset();
    rst_n = 1'b1;
    t_echo();
    t_counts();
    t_fault();
    t_delim();
    t_exc();
    t_listen();
    tally_and_finish();
  end
  initial begin
    #200000;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : tb_top
